//--- pio_checker_properties.sv
// concurrent properties watching the link between the two pio ends
module pio_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_wr,
  input wire logic nien,
  input wire logic stat_rd,
  input wire logic alt_rd,
  input wire logic data_rd,
  input wire logic bsy,
  input wire logic drq,
  input wire logic err,
  input wire logic intrq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_BSY_AFTER_CMD: assert property (cmd_wr |=> bsy)
    else $error("busy not raised after command write");
  AST_ABORT_FLAGS: assert property ($rose(err) |-> !bsy && !drq && (intrq == !nien))
    else $error("abort left wrong busy, drq or interrupt");
  AST_READY_QUIET: assert property ($rose(drq) && nien |-> !bsy && !intrq)
    else $error("block ready with interrupts off raised interrupt");
  AST_READY_INTRQ: assert property ($rose(drq) && !nien |-> !bsy && intrq)
    else $error("block ready with interrupts on lacks interrupt");
  AST_STAT_ACK: assert property (intrq && drq && stat_rd |=> !intrq && drq)
    else $error("status read did not acknowledge interrupt");
  AST_XFER_LEVELS: assert property (drq |-> !bsy)
    else $error("busy and drq high together");
  // drq may only drop because a read ended a block or a new command came
  AST_DRQ_DROP: assert property ($fell(drq) |-> $past(data_rd) || $past(cmd_wr))
    else $error("drq dropped without a data read");
  AST_FINAL_QUIET: assert property ($fell(drq) && !bsy |-> !intrq && !err [*3])
    else $error("final block raised interrupt or error");
  // the host waits its full settle count, so the quiet span is checked to its end
  AST_CMD_SETTLE: assert property (cmd_wr |=> !stat_rd [*8] ##1 !stat_rd)
    else $error("status read too soon after command");
  AST_BLOCK_SETTLE: assert property (alt_rd |=> !stat_rd [*8] ##1 !stat_rd [*6])
    else $error("status read too soon after block");
  AST_WORD_GAP: assert property (data_rd |=> !data_rd [*2])
    else $error("data reads too close together");
endmodule

//--- pio_dev.sv
// device end of the pio data-in protocol
// Summary of operation
// - raise busy promptly after command write
// - identify commands sample cable into word 93
// - abort: error, clear busy, interrupt if enabled
// - interrupts off: block ready goes to transfer
// - interrupts on: drq plus interrupt, await status
// - status read clears interrupt, starts transfer
// - transfer: busy clear, drq set, word ready
// - each read advances; block end re-prepares
// - final read: idle, no interrupt raised
// - host waits interrupt or polls per nien
// - host waits 400 ns before first status when polling (nien set)
// - host waits one pio cycle after block when polling (nien set)
// - host polls busy, transfers on drq, else error
// - host reads words until block completes
// - host returns idle after final block
module pio_dev
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pio_link.dev_mp lnk,
  input wire logic cable_det,
  input wire logic blk_ready,
  input wire logic blk_abort,
  input wire logic [15:0] word_in,
  output logic prep_r,
  output logic [8:0] blk_idx_r,
  output logic [7:0] word_idx_r,
  output logic [7:0] cmd_r,
  output logic [15:0] id_w93_r
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {D_IDLE, D_PREP, D_IRQ, D_XFER} dstate_e;

  dstate_e st_r;
  dstate_e st_nxt;
  logic [8:0] blks_r;
  logic pend_r;
  logic pend_nxt;
  logic bsy_r;
  logic drq_r;
  logic err_r;
  logic intrq_r;
  logic [15:0] data_r;

  // ----------------------------------------------------------------
  // decode of link strobes
  // ----------------------------------------------------------------
  wire in_prep = (st_r == D_PREP);
  wire in_irq = (st_r == D_IRQ);
  wire in_xfer = (st_r == D_XFER);
  // a data read outside the transfer state is ignored and moves nothing
  wire rd_word = in_xfer && lnk.data_rd;
  wire last_word = (word_idx_r == WORD_LAST);
  wire last_blk = (blk_idx_r == (blks_r - 9'h001));
  wire end_blk = rd_word && last_word;
  wire end_cmd = end_blk && last_blk;
  // abort wins over a block that turns ready in the same cycle
  wire prep_abort = in_prep && blk_abort;
  wire prep_done = in_prep && !blk_abort && blk_ready;
  wire irq_ack = in_irq && lnk.stat_rd;
  wire idle_ack = (st_r == D_IDLE) && lnk.stat_rd;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (lnk.cmd_wr) begin
      st_nxt = D_PREP;
    end else begin
      unique case (st_r)
        D_IDLE: st_nxt = D_IDLE;
        D_PREP: begin
          if (prep_abort) begin
            st_nxt = D_IDLE;
          end else if (prep_done) begin
            st_nxt = lnk.nien ? D_XFER : D_IRQ;
          end
        end
        D_IRQ: begin
          if (irq_ack) begin
            st_nxt = D_XFER;
          end
        end
        D_XFER: begin
          if (end_cmd) begin
            st_nxt = D_IDLE;
          end else if (end_blk) begin
            st_nxt = D_PREP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt pending
  // ----------------------------------------------------------------
  // set by a ready block while nien is low, or by an abort; a status read or a new command
  // clears it. nien also masks the pin, so a pending abort survives a mask.
  always_comb begin
    pend_nxt = pend_r;
    if (lnk.cmd_wr || irq_ack || idle_ack) begin
      pend_nxt = 1'b0;
    end
    if (prep_done && !lnk.nien) begin
      pend_nxt = 1'b1;
    end
    if (prep_abort) begin
      pend_nxt = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state, status bits and the pin
  // ----------------------------------------------------------------
  // status bits follow the next state so they change at the same edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= D_IDLE;
      pend_r <= 1'b0;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      intrq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      bsy_r <= (st_nxt == D_PREP);
      drq_r <= (st_nxt == D_IRQ) || (st_nxt == D_XFER);
      intrq_r <= pend_nxt && !lnk.nien;
    end
  end

  // ----------------------------------------------------------------
  // error bit
  // ----------------------------------------------------------------
  // stays up in idle so the host can read why the command ended
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else if (lnk.cmd_wr) begin
      err_r <= 1'b0;
    end else if (prep_abort) begin
      err_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // command capture and block geometry
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_r <= 8'h00;
      blks_r <= 9'h001;
    end else if (lnk.cmd_wr) begin
      cmd_r <= lnk.cmd_code;
      blks_r <= blocks_of(lnk.cmd_code, lnk.cmd_count);
    end
  end

  // ----------------------------------------------------------------
  // word and block indices
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_idx_r <= 8'h00;
      blk_idx_r <= 9'h000;
    end else if (lnk.cmd_wr) begin
      word_idx_r <= 8'h00;
      blk_idx_r <= 9'h000;
    end else if (rd_word) begin
      word_idx_r <= word_idx_r + 8'h01;
      if (last_word) begin
        blk_idx_r <= blk_idx_r + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // data register
  // ----------------------------------------------------------------
  // reloaded every cycle from the word source addressed by the indices;
  // the host must leave WORD_GAP_CYC between reads for the new word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= 16'h0000;
    end else begin
      data_r <= word_in;
    end
  end

  // ----------------------------------------------------------------
  // preparation request and cable sense
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prep_r <= 1'b0;
      id_w93_r <= 16'h0000;
    end else begin
      prep_r <= (st_nxt == D_PREP);
      if (in_prep && is_ident(cmd_r)) begin
        id_w93_r[W93_CBL_BIT] <= cable_det;
      end
    end
  end

  // ----------------------------------------------------------------
  // link outputs
  // ----------------------------------------------------------------
  assign lnk.bsy = bsy_r;
  assign lnk.drq = drq_r;
  assign lnk.err = err_r;
  assign lnk.intrq = intrq_r;
  assign lnk.data = data_r;

endmodule

//--- pio_host.sv
// controller end of the pio data-in protocol with an axi4-lite register port
module pio_host
  import pio_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  pio_link.host_mp lnk,
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq
);

  typedef enum logic [2:0] {H_IDLE, H_INTRQ, H_WAIT, H_CHECK, H_XFER, H_GAP} hstate_e;

  hstate_e st_r;
  hstate_e st_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic nien_r;
  logic [7:0] cmd_r;
  logic [7:0] cnt8_r;
  logic [8:0] blks_r;
  logic [8:0] blk_r;
  logic [7:0] word_r;
  logic [15:0] rx_word_r;
  logic [2:0] ist_r;
  logic [2:0] mask_r;
  logic [2:0] ev;
  logic cmd_wr_r;
  logic stat_rd_r;
  logic alt_rd_r;
  logic data_rd_r;
  logic aw_r;
  logic b_r;
  logic ar_r;
  logic r_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic irq_r;

  // ----------------------------------------------------------------
  // axi4-lite decode
  // ----------------------------------------------------------------
  // address and data are taken together; the ready pulse marks the take
  wire wr_go = awvalid && wvalid && !aw_r && !b_r;
  wire rd_go = arvalid && !ar_r && !r_r;
  wire wr_ctrl = aw_r && (awaddr == REG_CTRL);
  wire wr_ist = aw_r && (awaddr == REG_IRQ_STAT);
  wire wr_mask = aw_r && (awaddr == REG_IRQ_MASK);
  wire wr_ok = (awaddr == REG_CTRL) || (awaddr == REG_IRQ_STAT) || (awaddr == REG_IRQ_MASK);
  wire go = wr_ctrl && wdata[CTRL_GO] && wstrb[0] && (st_r == H_IDLE);
  wire rd_ok = (araddr == REG_CTRL) || (araddr == REG_STAT) || (araddr == REG_IRQ_STAT)
               || (araddr == REG_IRQ_MASK) || (araddr == REG_RX_WORD);
  wire [31:0] rd_mux =
    (araddr == REG_CTRL) ? {8'h00, cnt8_r, cmd_r, 6'h00, nien_r, 1'b0} :
    (araddr == REG_STAT) ? {blk_r, word_r, 11'h000, st_r, (st_r != H_IDLE)} :
    (araddr == REG_IRQ_STAT) ? {29'h0, ist_r} :
    (araddr == REG_IRQ_MASK) ? {29'h0, mask_r} :
    (araddr == REG_RX_WORD) ? {16'h0000, rx_word_r} : 32'h0;

  // ----------------------------------------------------------------
  // protocol decode
  // ----------------------------------------------------------------
  wire blk_end = (st_r == H_XFER) && (word_r == WORD_LAST);
  wire cmd_end = blk_end && (blk_r == (blks_r - 9'h001));
  wire cnt_zero = (cnt_r == 5'h00);
  wire chk_busy = lnk.bsy;
  wire chk_data = !lnk.bsy && lnk.drq;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_zero ? 5'h00 : cnt_r - 5'h01;
    ev = 3'h0;
    unique case (st_r)
      H_IDLE: begin
        if (go) begin
          st_nxt = wdata[CTRL_NIEN] ? H_WAIT : H_INTRQ;
          cnt_nxt = 5'(STAT_WAIT_CYC - 1);
        end
      end
      H_INTRQ: begin
        if (lnk.intrq) begin
          st_nxt = H_CHECK;
        end
      end
      H_WAIT: begin
        if (cnt_zero) begin
          st_nxt = H_CHECK;
        end
      end
      H_CHECK: begin
        if (chk_data) begin
          st_nxt = H_XFER;
        end else if (!chk_busy) begin
          st_nxt = H_IDLE;
          ev[IRQ_ERR] = 1'b1;
        end
      end
      H_XFER: begin
        ev[IRQ_WORD] = 1'b1;
        if (cmd_end) begin
          st_nxt = H_IDLE;
          ev[IRQ_DONE] = 1'b1;
        end else if (blk_end) begin
          st_nxt = nien_r ? H_WAIT : H_INTRQ;
          cnt_nxt = 5'(PIO_CYCLE_CYC - 1);
        end else begin
          st_nxt = H_GAP;
          cnt_nxt = 5'(WORD_GAP_CYC - 2);
        end
      end
      H_GAP: begin
        if (cnt_zero) begin
          st_nxt = H_XFER;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state and link strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      cnt_r <= 5'h00;
      cmd_wr_r <= 1'b0;
      stat_rd_r <= 1'b0;
      alt_rd_r <= 1'b0;
      data_rd_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cmd_wr_r <= go;
      stat_rd_r <= (st_nxt == H_CHECK);
      alt_rd_r <= blk_end && !cmd_end && nien_r;
      data_rd_r <= (st_nxt == H_XFER);
    end
  end

  // ----------------------------------------------------------------
  // command and word counting
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      nien_r <= 1'b0;
      cmd_r <= 8'h00;
      cnt8_r <= 8'h00;
      blks_r <= 9'h001;
      blk_r <= 9'h000;
      word_r <= 8'h00;
      rx_word_r <= 16'h0000;
    end else if (go) begin
      nien_r <= wdata[CTRL_NIEN];
      cmd_r <= wdata[CTRL_CMD_LSB +: 8];
      cnt8_r <= wdata[CTRL_CNT_LSB +: 8];
      blks_r <= blocks_of(wdata[CTRL_CMD_LSB +: 8], wdata[CTRL_CNT_LSB +: 8]);
      blk_r <= 9'h000;
      word_r <= 8'h00;
    end else if (st_r == H_XFER) begin
      rx_word_r <= lnk.data;
      word_r <= word_r + 8'h01;
      if (blk_end) begin
        blk_r <= blk_r + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // an event in the cycle of its write-one-to-clear keeps the bit set
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ist_r <= 3'h0;
      mask_r <= 3'h0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~(wr_ist ? wdata[2:0] : 3'h0)) | ev;
      if (wr_mask) begin
        mask_r <= wdata[2:0];
      end
      irq_r <= |(((ist_r & ~(wr_ist ? wdata[2:0] : 3'h0)) | ev) & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_r <= 1'b0;
      b_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      ar_r <= 1'b0;
      r_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_r <= wr_go;
      ar_r <= rd_go;
      if (aw_r) begin
        b_r <= 1'b1;
        bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        b_r <= 1'b0;
      end
      if (ar_r) begin
        r_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        r_r <= 1'b0;
      end
    end
  end

  assign awready = aw_r;
  assign wready = aw_r;
  assign bvalid = b_r;
  assign bresp = bresp_r;
  assign arready = ar_r;
  assign rvalid = r_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq = irq_r;
  assign lnk.cmd_wr = cmd_wr_r;
  assign lnk.cmd_code = cmd_r;
  assign lnk.cmd_count = cnt8_r;
  assign lnk.nien = nien_r;
  assign lnk.stat_rd = stat_rd_r;
  assign lnk.alt_rd = alt_rd_r;
  assign lnk.data_rd = data_rd_r;

endmodule

//--- pio_link.sv
// task-file link between the controller end and the device end
interface pio_link;
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic [7:0] cmd_count;
  logic nien;
  logic stat_rd;
  logic alt_rd;
  logic data_rd;
  logic bsy;
  logic drq;
  logic err;
  logic intrq;
  logic [15:0] data;

  modport dev_mp (
    input cmd_wr, cmd_code, cmd_count, nien, stat_rd, alt_rd, data_rd,
    output bsy, drq, err, intrq, data
  );
  modport host_mp (
    output cmd_wr, cmd_code, cmd_count, nien, stat_rd, alt_rd, data_rd,
    input bsy, drq, err, intrq, data
  );
endinterface

//--- pio_pkg.sv
// shared constants, command decode and timing counts for the pio data-in link
package pio_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int T_STAT_WAIT_NS = 400;
  localparam int T_PIO_CYCLE_NS = 600;
  // least times round up to whole cycles
  localparam int STAT_WAIT_CYC = (T_STAT_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int PIO_CYCLE_CYC = (T_PIO_CYCLE_NS * CLK_MHZ + 999) / 1000;
  // cycles between two data reads: index update, word fetch, data register load
  localparam int WORD_GAP_CYC = 3;

  // ----------------------------------------------------------------
  // block geometry and commands
  // ----------------------------------------------------------------
  localparam logic [7:0] WORD_LAST = 8'hff;
  localparam logic [7:0] CMD_IDENT_DEV = 8'hec;
  localparam logic [7:0] CMD_IDENT_PKT = 8'ha1;
  localparam int W93_CBL_BIT = 13;

  // ----------------------------------------------------------------
  // controller registers (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK = 5'h0c;
  localparam logic [4:0] REG_RX_WORD = 5'h10;
  localparam int CTRL_GO = 0;
  localparam int CTRL_NIEN = 1;
  localparam int CTRL_CMD_LSB = 8;
  localparam int CTRL_CNT_LSB = 16;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_WORD = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // identify-type commands carry one block; a count of zero means 256 blocks
  function automatic logic is_ident(input logic [7:0] code);
    return (code == CMD_IDENT_DEV) || (code == CMD_IDENT_PKT);
  endfunction

  function automatic logic [8:0] blocks_of(input logic [7:0] code, input logic [7:0] cnt);
    if (is_ident(code)) begin
      return 9'h001;
    end
    return (cnt == 8'h00) ? 9'h100 : {1'b0, cnt};
  endfunction

endpackage

//--- tb.sv
// self-checking bench joining controller and device ends over the link
module tb
  import pio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic cable_det = 1'b0, blk_ready = 1'b0, blk_abort = 1'b0, ab_mode = 1'b0;
  logic [15:0] word_in = 16'h0000;
  logic awready, wready, bvalid, arready, rvalid, irq, prep_r, intrq_q;
  logic [1:0] bresp, rresp, r0;
  logic [31:0] rdata, v0;
  logic [8:0] blk_idx_r;
  logic [7:0] word_idx_r, exp_w, exp_b, dev_cmd;
  logic [15:0] w93;
  int n_fail = 0, comparisons = 0, n_words = 0, n_rise = 0, prep_cnt = 0;

  pio_link lnk();
  pio_dev u_pio_dev (.clock(clock), .rst_n(rst_n), .lnk(lnk), .cable_det(cable_det),
    .blk_ready(blk_ready), .blk_abort(blk_abort), .word_in(word_in), .prep_r(prep_r),
    .blk_idx_r(blk_idx_r), .word_idx_r(word_idx_r), .cmd_r(dev_cmd), .id_w93_r(w93));
  pio_host u_pio_host (.clock(clock), .rst_n(rst_n), .lnk(lnk), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq));
  pio_checker u_pio_checker (.clock(clock), .rst_n(rst_n), .cmd_wr(lnk.cmd_wr),
    .nien(lnk.nien), .stat_rd(lnk.stat_rd), .alt_rd(lnk.alt_rd), .data_rd(lnk.data_rd),
    .bsy(lnk.bsy), .drq(lnk.drq), .err(lnk.err), .intrq(lnk.intrq));

  always #20 clock = ~clock;

  // device back end: block is ready only after 20 cycles, so the host must poll busy
  always @(posedge clock) begin
    prep_cnt <= prep_r ? prep_cnt + 1 : 0;
    blk_ready <= prep_r && prep_cnt > 20 && !ab_mode;
    blk_abort <= prep_r && prep_cnt > 20 && ab_mode;
    word_in <= {blk_idx_r[7:0], word_idx_r} ^ 16'h5a00;
  end

  // link monitor: every data read must carry the next word in order
  always @(posedge clock) begin
    intrq_q <= lnk.intrq;
    if (lnk.cmd_wr) begin
      n_words = 0;
      n_rise = 0;
      exp_w = 8'h00;
      exp_b = 8'h00;
    end
    if (lnk.intrq && !intrq_q) n_rise++;
    if (lnk.data_rd && lnk.drq) begin
      check({16'h0000, lnk.data}, {16'h0000, {exp_b, exp_w} ^ 16'h5a00});
      n_words++;
      if (exp_w == WORD_LAST) exp_b++;
      exp_w++;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // bready is raised with the request so the answer is never missed
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        r = bresp;
      end
    end
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic got;
    got = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
  endtask

  // one whole command: start, wait for done or error, judge, then clear status
  task automatic run_cmd(input logic ni, input logic [7:0] cmd, input logic [7:0] cnt,
                         input logic ab, input int nblk);
    logic [31:0] v;
    logic [1:0] r;
    int k;
    k = 0;
    ab_mode <= ab;
    axi_wr(REG_IRQ_MASK, 32'h00000003, r);
    axi_wr(REG_CTRL, {8'h00, cnt, cmd, 6'h00, ni, 1'b1}, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    // a second start while busy must be ignored and leave the control word alone
    axi_wr(REG_CTRL, {8'h07, 8'h07, 8'h30, 6'h00, !ni, 1'b1}, r);
    axi_rd(REG_CTRL, v, r);
    check(v, {8'h00, cnt, cmd, 6'h00, ni, 1'b0});
    check({24'h0, dev_cmd}, {24'h0, cmd});
    while (irq !== 1'b1 && k < 1500 * nblk + 500) begin
      @(posedge clock);
      k++;
    end
    check({31'h0, irq}, 32'h00000001);
    axi_rd(REG_IRQ_STAT, v, r);
    check({31'h0, v[IRQ_ERR]}, {31'h0, ab});
    check(n_words, nblk * 256);
    check(n_rise, ni ? 0 : (ab ? 1 : nblk));
    if (!ab) begin
      axi_rd(REG_RX_WORD, v, r);
      check({16'h0, v[15:0]}, {16'h0, {8'(nblk - 1), WORD_LAST} ^ 16'h5a00});
    end
    if (cmd == CMD_IDENT_DEV || cmd == CMD_IDENT_PKT) begin
      check({16'h0, w93}, {18'h0, cable_det, 13'h0});
    end
    axi_rd(REG_STAT, v, r);
    check({31'h0, v[0]}, 32'h00000000);
    axi_wr(REG_IRQ_STAT, 32'h00000007, r);
    axi_rd(REG_IRQ_STAT, v, r);
    check(v, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
  endtask

  // reset values of every register, an unmapped read at 0x14 and write at 0x18, and a start with byte 0 masked
  task automatic reset_values();
    for (int i = 0; i < 6; i++) begin
      axi_rd(5'(i * 4), v0, r0);
      check(v0, 32'h00000000);
      check({30'h0, r0}, {30'h0, (i == 5) ? RESP_SLVERR : RESP_OKAY});
    end
    axi_wr(5'h18, 32'hffffffff, r0);
    check({30'h0, r0}, {30'h0, RESP_SLVERR});
    wstrb <= 4'he;
    axi_wr(REG_CTRL, 32'h00000001, r0);
    wstrb <= 4'hf;
    axi_rd(REG_STAT, v0, r0);
    check(v0, 32'h00000000);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    reset_values();
    run_cmd(1'b1, 8'h20, 8'h02, 1'b0, 2);
    run_cmd(1'b0, 8'h20, 8'h02, 1'b0, 2);
    cable_det <= 1'b1;
    run_cmd(1'b0, CMD_IDENT_DEV, 8'h05, 1'b0, 1);
    cable_det <= 1'b0;
    run_cmd(1'b1, CMD_IDENT_PKT, 8'h00, 1'b0, 1);
    run_cmd(1'b0, 8'h20, 8'h01, 1'b1, 0);
    run_cmd(1'b1, 8'h20, 8'h01, 1'b1, 0);
    print_verdict();
  end

  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    print_verdict();
  end
endmodule
